// [src/sabc_host.sv]
// host controller that starts conversions and reads the result bus
module sabc_host
	import sabc_pkg::*;
(
	input  wire logic               mclk,
	input  wire logic               nrst,
	input  wire logic               req,
	input  wire logic               continuous,
	input  wire logic               stop,
	input  wire logic               irq,
	input  wire logic [DATA_W-1:0]  result_bus,
	input  wire logic               range_exceeded,
	output sabc_ctrl_t              ctrl,
	output sabc_result_t            result,
	output logic                    result_valid,
	output logic                    timeout_err,
	output logic                    busy
);
	// ================================================================
	// state
	typedef enum logic [3:0] {
		ST_IDLE, ST_SETUP, ST_STROBE, ST_WAIT_HI, ST_WAIT_LO,
		ST_READ_HI, ST_READ_LO, ST_RELEASE, ST_ACQ
	} sabc_state_t;

	sabc_state_t      state_ff,  nxt_state;
	sabc_ctrl_t       ctrl_ff,   nxt_ctrl;
	sabc_result_t     res_ff,    nxt_res;
	logic             rv_ff,     nxt_rv;
	logic             err_ff,    nxt_err;
	logic             busy_ff,   nxt_busy;
	logic             cont_ff,   nxt_cont;
	logic [BYTE_W-1:0] hi_ff,    nxt_hi;
	logic             ld;
	logic [CNT_W-1:0] ld_val;
	logic             t_done;

	sabc_timer u_timer (
		.mclk  (mclk),
		.nrst  (nrst),
		.load  (ld),
		.value (ld_val),
		.done  (t_done)
	);

	// ================================================================
	// sequencer
	always_comb
	begin
		nxt_state = state_ff;
		nxt_ctrl  = ctrl_ff;
		nxt_res   = res_ff;
		nxt_rv    = 1'b0;
		nxt_err   = 1'b0;
		nxt_busy  = 1'b1;
		nxt_cont  = cont_ff;
		nxt_hi    = hi_ff;
		ld        = 1'b0;
		ld_val    = '0;
		case (state_ff)
			ST_IDLE:
			begin
				nxt_busy = 1'b0;
				nxt_ctrl = '{chip_sel_n: 1'b1, start_strobe_n: 1'b1,
					out_en_n: 1'b1, byte_select_n: 1'b0};
				if (req)
				begin
					// select first so the strobe edge is the last qualifier
					nxt_ctrl.chip_sel_n = 1'b0;
					nxt_cont  = continuous;
					nxt_busy  = 1'b1;
					ld        = 1'b1;
					ld_val    = CNT_W'(SETTLE_CY);
					nxt_state = ST_SETUP;
				end
			end
			ST_SETUP:
				if (t_done)
				begin
					nxt_ctrl.start_strobe_n = 1'b0;
					ld        = 1'b1;
					ld_val    = CNT_W'(IRQ_WAIT_CY);
					nxt_state = ST_STROBE;
				end
			ST_STROBE:
				if (irq)
				begin
					ld        = 1'b1;
					ld_val    = CNT_W'(BUSY_WAIT_CY);
					nxt_state = ST_WAIT_HI;
				end
				else if (t_done)
				begin
					nxt_err   = 1'b1;
					nxt_state = ST_RELEASE;
				end
			ST_WAIT_HI:
			begin
				// strobe kept low past its least width; released unless continuous with stop low
				if (!cont_ff || stop)
					nxt_ctrl.start_strobe_n = 1'b1;
				if (!irq)
				begin
					// data valid once busy falls; enable then settle
					nxt_ctrl.out_en_n      = 1'b0;
					nxt_ctrl.byte_select_n = 1'b0;
					ld        = 1'b1;
					ld_val    = CNT_W'(SETTLE_CY);
					nxt_state = ST_READ_HI;
				end
				else if (t_done)
				begin
					nxt_err   = 1'b1;
					nxt_state = ST_RELEASE;
				end
			end
			ST_READ_HI:
			begin
				if (!cont_ff || stop)
					nxt_ctrl.start_strobe_n = 1'b1;
				if (t_done)
				begin
					nxt_hi = result_bus[DATA_W-1 -: BYTE_W];
					nxt_res.range_exceeded = range_exceeded;
					nxt_ctrl.byte_select_n = 1'b1;
					ld        = 1'b1;
					ld_val    = CNT_W'(BSEL_CY);
					nxt_state = ST_READ_LO;
				end
			end
			ST_READ_LO:
				if (t_done)
				begin
					nxt_res.data = {hi_ff, result_bus[DATA_W-1 -: NIB_W]};
					nxt_rv    = 1'b1;
					nxt_ctrl.out_en_n      = 1'b1;
					nxt_ctrl.byte_select_n = 1'b0;
					if (cont_ff && !stop && !ctrl_ff.start_strobe_n)
					begin
						ld        = 1'b1;
						ld_val    = CNT_W'(BUSY_WAIT_CY + IRQ_WAIT_CY);
						nxt_state = ST_STROBE;
					end
					else
						nxt_state = ST_RELEASE;
				end
			ST_RELEASE:
			begin
				nxt_ctrl.start_strobe_n = 1'b1;
				nxt_ctrl.out_en_n       = 1'b1;
				ld        = 1'b1;
				ld_val    = CNT_W'(ACQ_CY);
				nxt_state = ST_ACQ;
			end
			ST_ACQ:
				if (t_done)
				begin
					// select rises last, after strobe and enable
					nxt_ctrl.chip_sel_n = 1'b1;
					nxt_state = ST_IDLE;
				end
			default:
				nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_ff <= ST_IDLE;
			ctrl_ff  <= '{chip_sel_n: 1'b1, start_strobe_n: 1'b1,
				out_en_n: 1'b1, byte_select_n: 1'b0};
			res_ff   <= '0;
			rv_ff    <= 1'b0;
			err_ff   <= 1'b0;
			busy_ff  <= 1'b0;
			cont_ff  <= 1'b0;
			hi_ff    <= '0;
		end
		else
		begin
			state_ff <= nxt_state;
			ctrl_ff  <= nxt_ctrl;
			res_ff   <= nxt_res;
			rv_ff    <= nxt_rv;
			err_ff   <= nxt_err;
			busy_ff  <= nxt_busy;
			cont_ff  <= nxt_cont;
			hi_ff    <= nxt_hi;
		end
	end

	assign ctrl         = ctrl_ff;
	assign result       = res_ff;
	assign result_valid = rv_ff;
	assign timeout_err  = err_ff;
	assign busy         = busy_ff;

	// ================================================================
	// checks
	a_sel_before_strobe: assert property (@(posedge mclk) disable iff (!nrst)
		$fell(ctrl_ff.start_strobe_n) |-> !ctrl_ff.chip_sel_n && !$past(ctrl_ff.chip_sel_n))
		else $error("start strobe fell without select held");
	a_strobe_min_low: assert property (@(posedge mclk) disable iff (!nrst)
		$fell(ctrl_ff.start_strobe_n) |=> !ctrl_ff.start_strobe_n [*2])
		else $error("start strobe low too short");
	a_oe_under_sel: assert property (@(posedge mclk) disable iff (!nrst)
		!ctrl_ff.out_en_n |-> !ctrl_ff.chip_sel_n)
		else $error("enable low without select");
	a_bsel_in_acq: assert property (@(posedge mclk) disable iff (!nrst)
		$changed(ctrl_ff.byte_select_n) && !ctrl_ff.out_en_n |-> !irq)
		else $error("byte select moved during conversion");
	a_valid_pulse: assert property (@(posedge mclk) disable iff (!nrst)
		rv_ff |=> !rv_ff)
		else $error("valid longer than one cycle");
	a_sel_min_high: assert property (@(posedge mclk) disable iff (!nrst)
		$rose(ctrl_ff.chip_sel_n) |=> ctrl_ff.chip_sel_n)
		else $error("select pulse too short");
	c_single: cover property (@(posedge mclk) disable iff (!nrst) rv_ff && !cont_ff);
	c_cont: cover property (@(posedge mclk) disable iff (!nrst) rv_ff && cont_ff);
	c_timeout: cover property (@(posedge mclk) disable iff (!nrst) err_ff);
endmodule

// [src/sabc_pkg.sv]
// shared constants, types and timing for the converter host controller
// Notes on behaviour
// - host holds select low for start and read
// - host changes byte select only during acquisition
// - host start strobe low at least 10 ns
// - host enable and select pulses at least 15 ns; select stays high for only one 8 ns cycle if req is high on entry to ST_IDLE
package sabc_pkg;
	localparam int CLK_NS       = 8;
	localparam int START_LOW_NS = 60;
	localparam int EN_SETTLE_NS = 25;
	localparam int BSEL_NS      = 25;
	localparam int IRQ_MAX_NS   = 25;
	localparam int BUSY_MAX_NS  = 230;
	localparam int ACQ_NS       = 100;
	localparam int START_LOW_CY = (START_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int SETTLE_CY    = (EN_SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int BSEL_CY      = (BSEL_NS + CLK_NS - 1) / CLK_NS;
	localparam int IRQ_WAIT_CY  = (IRQ_MAX_NS + CLK_NS - 1) / CLK_NS + 1;
	localparam int BUSY_WAIT_CY = (BUSY_MAX_NS + CLK_NS - 1) / CLK_NS + 2;
	localparam int ACQ_CY       = (ACQ_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W        = 6;
	localparam int DATA_W       = 12;
	localparam int BYTE_W       = 8;
	localparam int NIB_W        = 4;
	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic              range_exceeded;
	} sabc_result_t;
	typedef struct packed {
		logic chip_sel_n;
		logic start_strobe_n;
		logic out_en_n;
		logic byte_select_n;
	} sabc_ctrl_t;
endpackage

// [src/sabc_timer.sv]
// down counter that flags when a loaded wait has run out
module sabc_timer
	import sabc_pkg::*;
(
	input  wire logic             mclk,
	input  wire logic             nrst,
	input  wire logic             load,
	input  wire logic [CNT_W-1:0] value,
	output logic                  done
);
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	always_comb
	begin
		nxt_cnt = cnt_ff;
		if (load)
			nxt_cnt = value;
		else if (cnt_ff != '0)
			nxt_cnt = cnt_ff - 1'b1;
	end
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			cnt_ff <= '0;
		else
			cnt_ff <= nxt_cnt;
	end
	// done is not gated by load: the sequencer loads on done, a gate would loop
	assign done = (cnt_ff == '0);
endmodule

// [tb/sabc_adc_model.sv]
// behavioural model of the converter pins as the host controller sees them
module sabc_adc_model
	import sabc_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              nrst,
	input  wire sabc_ctrl_t        ctrl,
	input  wire logic [DATA_W-1:0] sample,
	input  wire logic              over,
	input  wire logic              dead,
	output logic                   irq,
	output logic [DATA_W-1:0]      result_bus,
	output logic                   range_exceeded
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// conversion sequencing
	logic [1:0]  ph;
	logic [5:0]  cnt;
	logic [12:0] held;
	logic [12:0] latch;
	logic        cs_d;
	logic        st_d;
	logic        drive;
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			ph <= 2'h0;
			cnt <= 6'h00;
			irq <= 1'b0;
			held <= 13'h0000;
			latch <= 13'h0000;
			cs_d <= 1'b1;
			st_d <= 1'b1;
		end
		else
		begin
			cs_d <= ctrl.chip_sel_n;
			st_d <= ctrl.start_strobe_n;
			cnt <= cnt + 6'h01;
			case (ph)
				// whichever qualifier arrives last starts it
				2'h0: if (!ctrl.chip_sel_n && !ctrl.start_strobe_n && (cs_d || st_d))
				begin
					ph <= 2'h1;
					held <= {sample, over};
				end
				// dead stands for a stuck converter, released by select going high
				2'h1: if (!dead)
				begin
					ph <= 2'h2;
					irq <= 1'b1;
					cnt <= 6'h00;
				end
				else if (ctrl.chip_sel_n)
					ph <= 2'h0;
				// 25 cycles of hold, 200 ns
				2'h2: if (cnt == 6'h18)
				begin
					irq <= 1'b0;
					latch <= held;
					ph <= 2'h3;
					cnt <= 6'h00;
				end
				// 13 cycles of acquisition, whole cycle 312 ns
				default: if (cnt == 6'h0C)
				begin
					ph <= 2'h0;
					if (!ctrl.chip_sel_n && !ctrl.start_strobe_n)
					begin
						ph <= 2'h1;
						held <= {sample, over};
					end
				end
			endcase
		end
	end
	// ==========================================
	// three-state outputs, undriven lines show the inverse
	assign drive = !ctrl.chip_sel_n && !ctrl.out_en_n;
	assign result_bus = !drive ? ~latch[12:1] :
		ctrl.byte_select_n ? {latch[4:1], 8'h00} : latch[12:1];
	assign range_exceeded = drive ? latch[0] : ~latch[0];
endmodule

// [tb/test_sampling_adc_bus_control.sv]
// self-checking bench for the converter host controller
module test_sampling_adc_bus_control import sabc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic              mclk;
	logic              nrst;
	logic              req;
	logic              continuous;
	logic              stop;
	logic              irq;
	logic [DATA_W-1:0] result_bus;
	logic              range_exceeded;
	logic [DATA_W-1:0] sample;
	logic              over;
	logic              dead;
	sabc_ctrl_t        ctrl;
	sabc_result_t      result;
	logic              result_valid;
	logic              timeout_err;
	logic              busy;
	int                fails;
	int                n_checks;
	// ==========================================
	// instances and clock
	sabc_host i_sabc_host (.mclk(mclk), .nrst(nrst), .req(req), .continuous(continuous),
		.stop(stop), .irq(irq), .result_bus(result_bus), .range_exceeded(range_exceeded),
		.ctrl(ctrl), .result(result), .result_valid(result_valid),
		.timeout_err(timeout_err), .busy(busy));
	sabc_adc_model i_sabc_adc_model (.mclk(mclk), .nrst(nrst), .ctrl(ctrl), .sample(sample),
		.over(over), .dead(dead), .irq(irq), .result_bus(result_bus),
		.range_exceeded(range_exceeded));
	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// ==========================================
	// compare, wait, start and closing tasks
	task automatic chk_res(input sabc_result_t got, input sabc_result_t exp);
		n_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %0t result %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		n_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %0t flag %b expected %b", $time, got, exp);
		end
	endtask
	task automatic test_done();
		if (fails == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// 0: result or timeout pulse, 1: sequence idle, 2: busy line high
	task automatic wait_on(input int w);
		for (int i = 0; i < 400; i++)
		begin
			@(negedge mclk);
			if ((w == 0 && (result_valid === 1'b1 || timeout_err === 1'b1)) ||
				(w == 1 && busy === 1'b0) || (w == 2 && irq === 1'b1))
				return;
		end
		fails++;
		$display("[ERR] %0t wait %0d ran out", $time, w);
		test_done();
	endtask
	task automatic start(input logic cont);
		continuous = cont;
		req = 1'b1;
		@(negedge mclk);
		req = 1'b0;
	endtask
	// ==========================================
	// scenarios
	task automatic do_single(input logic [DATA_W-1:0] v, input logic o);
		sample = v;
		over = o;
		start(1'b0);
		wait_on(0);
		chk_bit(timeout_err, 1'b0);
		chk_res(result, '{data: v, range_exceeded: o});
		wait_on(1);
		chk_bit(ctrl.chip_sel_n, 1'b1);
		chk_bit(ctrl.start_strobe_n, 1'b1);
	endtask
	task automatic do_cont();
		sample = 12'h123;
		over = 1'b0;
		start(1'b1);
		wait_on(2);
		sample = 12'h9AB;
		over = 1'b1;
		wait_on(0);
		chk_res(result, '{data: 12'h123, range_exceeded: 1'b0});
		wait_on(0);
		chk_res(result, '{data: 12'h9AB, range_exceeded: 1'b1});
		stop = 1'b1;
		continuous = 1'b0;
		wait_on(1);
		stop = 1'b0;
		chk_bit(ctrl.start_strobe_n, 1'b1);
	endtask
	task automatic do_dead();
		dead = 1'b1;
		start(1'b0);
		wait_on(0);
		chk_bit(timeout_err, 1'b1);
		wait_on(1);
		chk_bit(ctrl.chip_sel_n, 1'b1);
		dead = 1'b0;
	endtask
	initial
	begin
		nrst = 1'b0;
		req = 1'b0;
		continuous = 1'b0;
		stop = 1'b0;
		sample = 12'h000;
		over = 1'b0;
		dead = 1'b0;
		fails = 0;
		n_checks = 0;
		repeat (12) @(negedge mclk);
		nrst = 1'b1;
		@(negedge mclk);
		chk_bit(ctrl.chip_sel_n, 1'b1);
		do_single(12'hA5C, 1'b0);
		do_single(12'hFFF, 1'b1);
		do_single(12'h000, 1'b1);
		do_cont();
		do_dead();
		// recovery after a stuck conversion
		do_single(12'h5A5, 1'b0);
		test_done();
	end
endmodule
